// ---- hdl/btt_boost_target_tracker.sv ----
// Boost target computation, step-down hold and supply level ramp.
`timescale 1ns/100ps
`default_nettype none
`include "btt_defines.svh"
module btt_boost_target_tracker #(
    parameter int HOLD_MS_UNIT = `BTT_REF_PER_MS,
    parameter int US_UNIT      = `BTT_REF_PER_US
) (
    input  wire logic              sys_clk,              // System clock, 100 MHz.
    input  wire logic              rst,                  // Synchronous reset.
    input  wire btt_pkg::btt_code_t output_peak_level,   // Rectified peak level.
    input  wire btt_pkg::btt_code_t boost_signal_margin, // Margin above peak.
    input  wire btt_pkg::btt_code_t boost_ceiling_code,  // Target ceiling.
    input  wire btt_pkg::btt_code_t battery_level_code,  // Battery level as a code.
    input  wire logic [2:0]        ramp_step_period_sel, // Step period selector.
    input  wire logic [3:0]        stepdown_hold_sel,    // Step-down hold selector.
    input  wire logic [2:0]        sample_rate_range,    // Sample-rate range code.
    input  wire logic [1:0]        ratio_sel,            // Internal clock ratio.
    input  wire logic [3:0]        clk_mult,             // Clock multiplier.
    input  wire logic              mclk_above_2m,        // Master clock above 2 MHz.
    output btt_pkg::btt_code_t     boost_target_code,    // Computed target.
    output btt_pkg::btt_code_t     boosted_supply,       // Ramped supply code.
    output logic                   boost_active_flag_n,  // Low when not boosting.
    output logic                   converter_on,         // Converter running.
    output logic                   bypass_to_battery,    // Supply tied to battery.
    output logic                   ramping,              // Supply not at target.
    output logic [9:0]             eff_ratio_x2,         // Effective ratio times two.
    output logic [8:0]             osr_fixed,            // Fixed oversampling.
    output logic                   auto_div5,            // Divide by five active.
    output logic                   cfg_valid             // Clock setup legal.
);
    import btt_pkg::*;

    typedef struct packed {
        btt_code_t   tgt;
        btt_code_t   lvl;
        btt_code_t   pend;
        btt_mode_t   mode;
        logic [18:0] hold_cnt;
        logic [8:0]  step_cnt;
        logic        act_n;
        logic        conv;
        logic        byp;
        logic [2:0]  srate;
    } btt_st_t;

    btt_st_t   s_q, s_d;
    logic      ref_tick;
    btt_code_t calc;

    if (US_UNIT < 1 || US_UNIT > 2) begin : g_bad_us
        $error("US_UNIT unsupported");
    end
    if (HOLD_MS_UNIT < 1 || HOLD_MS_UNIT > 2000) begin : g_bad_hold
        $error("HOLD_MS_UNIT unsupported");
    end

    // Saturating peak plus margin, then capped at the ceiling.
    function automatic btt_code_t calc_target(btt_code_t pk, btt_code_t mg, btt_code_t lim);
        logic [6:0] sum;
        btt_code_t  sat;
        sum = {1'b0, pk} + {1'b0, mg}; // R3
        sat = sum[6] ? `BTT_CODE_MAX : sum[5:0]; // R2
        return (lim < sat) ? lim : sat; // R1
    endfunction : calc_target

    // Step period in reference cycles: microseconds times cycles per microsecond.
    function automatic logic [8:0] step_reload(logic [2:0] sel);
        logic [7:0] us;
        unique case (sel) // R11
            3'h0: us = 8'h04;
            3'h1: us = 8'h08;
            3'h2: us = 8'h10;
            3'h3: us = 8'h20;
            3'h4: us = 8'h01;
            3'h5: us = 8'h02;
            3'h6: us = 8'h40;
            3'h7: us = 8'h80;
        endcase
        return 9'(us * US_UNIT); // R19
    endfunction : step_reload

    // Hold time in reference cycles; selector values above 8 act as 128 ms.
    function automatic logic [18:0] hold_reload(logic [3:0] sel);
        logic [7:0] ms;
        if (sel == 4'h0) begin
            ms = 8'h00;
        end else if (sel > 4'h8) begin
            ms = 8'h80;
        end else begin
            ms = 8'(8'h01 << (sel - 4'h1));
        end
        return 19'(ms * HOLD_MS_UNIT); // R18
    endfunction : hold_reload

    btt_ref_tick u_ref_tick (
        .sys_clk (sys_clk),
        .rst     (rst),
        .ref_tick(ref_tick)
    );

    btt_clk_check u_clk_check (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .ratio_sel    (ratio_sel),
        .clk_mult     (clk_mult),
        .mclk_above_2m(mclk_above_2m),
        .eff_ratio_x2 (eff_ratio_x2),
        .osr_fixed    (osr_fixed),
        .auto_div5    (auto_div5),
        .cfg_valid    (cfg_valid)
    );

    always_comb begin
        s_d = s_q;
        s_d.srate = sample_rate_range; // R13
        calc = calc_target(output_peak_level, boost_signal_margin, boost_ceiling_code);

        // Target follows rises at once and falls only after the hold time.
        if (calc >= s_q.tgt) begin
            s_d.tgt  = calc; // R8
            s_d.mode = BTT_IDLE;
        end else if (s_q.mode != BTT_HOLD || calc != s_q.pend) begin
            s_d.pend     = calc;
            s_d.mode     = BTT_HOLD;
            s_d.hold_cnt = hold_reload(stepdown_hold_sel);
            if (stepdown_hold_sel == 4'h0) begin
                s_d.tgt  = calc; // R9
                s_d.mode = BTT_IDLE;
            end
        end else if (s_q.hold_cnt == 19'h00000) begin
            s_d.tgt  = s_q.pend; // R9 R18
            s_d.mode = BTT_IDLE;
        end else if (ref_tick) begin
            s_d.hold_cnt = s_q.hold_cnt - 19'h00001;
        end

        // Ramp the supply code one step per interval.
        if (s_q.lvl == s_q.tgt) begin
            s_d.step_cnt = step_reload(ramp_step_period_sel);
        end else if (ref_tick) begin
            if (s_q.step_cnt <= 9'h001) begin
                s_d.step_cnt = step_reload(ramp_step_period_sel); // R19
                if (s_q.lvl < s_q.tgt) begin
                    s_d.lvl = s_q.lvl + 6'h01; // R10
                end else begin
                    s_d.lvl = s_q.lvl - 6'h01; // R10
                end
            end else begin
                s_d.step_cnt = s_q.step_cnt - 9'h001; // R12
            end
        end

        s_d.act_n = (s_q.tgt < battery_level_code) ||
                    (s_q.tgt < `BTT_BOOST_MIN); // R4 R6
        s_d.conv  = (s_q.tgt >= `BTT_BOOST_MIN) &&
                    (output_peak_level >= battery_level_code); // R5 R7
        s_d.byp   = !s_d.conv; // R7
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q          <= '0;
            s_q.mode     <= BTT_IDLE;
            s_q.step_cnt <= 9'h008;
        end else begin
            s_q <= s_d;
        end
    end

    assign boost_target_code   = s_q.tgt;
    assign boosted_supply      = s_q.lvl;
    assign boost_active_flag_n = !s_q.act_n;
    assign converter_on        = s_q.conv;
    assign bypass_to_battery   = s_q.byp;
    assign ramping             = (s_q.lvl != s_q.tgt);
endmodule : btt_boost_target_tracker
`default_nettype wire

// ---- hdl/btt_clk_check.sv ----
// Checks the master clock setup and reports oversampling and divider.
`timescale 1ns/100ps
`default_nettype none
module btt_clk_check (
    input  wire logic       sys_clk,       // System clock.
    input  wire logic       rst,           // Synchronous reset.
    input  wire logic [1:0] ratio_sel,     // Internal ratio: 0=256,1=400,2=500.
    input  wire logic [3:0] clk_mult,      // Multiplier 1, 2, 4 or 8.
    input  wire logic       mclk_above_2m, // Master clock above 2 MHz.
    output logic [9:0]      eff_ratio_x2,  // Effective external ratio times two.
    output logic [8:0]      osr_fixed,     // Fixed oversampling, zero if free.
    output logic            auto_div5,     // Divide by five applied.
    output logic            cfg_valid      // Setup is legal.
);
    typedef struct packed {
        logic [9:0] eff;
        logic [8:0] osr;
        logic       div5;
        logic       ok;
    } btt_chk_st_t;
    btt_chk_st_t s_q, s_d;
    logic [9:0] base_x2;
    logic       mult_ok;
    always_comb begin
        s_d = s_q;
        unique case (ratio_sel)
            2'h1:    base_x2 = 10'h320;
            2'h2:    base_x2 = 10'h3E8;
            default: base_x2 = 10'h200;
        endcase
        mult_ok = (clk_mult == 4'h1) || (clk_mult == 4'h2) ||
                  (clk_mult == 4'h4) || (clk_mult == 4'h8);
        s_d.ok = (ratio_sel != 2'h3) && mult_ok &&
                 (clk_mult == 4'h1 || mclk_above_2m); // R14 R15
        unique case (clk_mult)
            4'h8:    s_d.eff = base_x2 >> 3; // R15
            4'h4:    s_d.eff = base_x2 >> 2;
            4'h2:    s_d.eff = base_x2 >> 1;
            default: s_d.eff = base_x2;
        endcase
        s_d.osr  = (ratio_sel == 2'h0) ? 9'h000 : 9'h064; // R16 R17
        s_d.div5 = (ratio_sel == 2'h2); // R17
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign eff_ratio_x2 = s_q.eff;
    assign osr_fixed    = s_q.osr;
    assign auto_div5    = s_q.div5;
    assign cfg_valid    = s_q.ok;
endmodule : btt_clk_check
`default_nettype wire

// ---- hdl/btt_defines.svh ----
// Constants of the boost target tracker.
// Behaviour
// R1: target is min of ceiling and peak-plus-margin.
// R2: peak-plus-margin sum saturates at 63.
// R3: peak input is unsigned 6-bit rectified level.
// R4: target code: 0.9 V plus 0.15 V steps.
// R5: converter off below code 12 (2.7 V).
// R6: active flag low below battery or 2.7 V.
// R7: peak below battery: converter off, bypass.
// R8: raise target immediately on level increase.
// R9: lower target only after programmable delay.
// R10: supply moves one code per step interval.
// R11: three-bit step period selector table.
// R12: step timing counts 2 MHz reference cycles.
// R13: software programs the sample-rate range code.
// R14: software sets clock ratio 256, 400, 500.
// R15: multiplier 8/4/2/1 scales master clock ratio.
// R16: ratio 256 allows oversampling 32 to 256.
// R17: ratios 400/500 fix oversampling at 100.
// R18: step-down hold selector 0 to 128 ms table.
// R19: step timer reloads period times two.
`ifndef BTT_DEFINES_SVH
`define BTT_DEFINES_SVH
`define BTT_CODE_W        6
`define BTT_CODE_MAX      6'h3F
`define BTT_BOOST_MIN     6'h0C
`define BTT_SYS_HZ        100000000
`define BTT_REF_HZ        2000000
`define BTT_REF_DIV       (`BTT_SYS_HZ / `BTT_REF_HZ)
`define BTT_REF_PER_US    2
`define BTT_REF_PER_MS    2000
`define BTT_STEP_RESET    3'h0
`define BTT_HOLD_RESET    4'h0
`define BTT_RATIO_256     2'h0
`define BTT_RATIO_400     2'h1
`define BTT_RATIO_500     2'h2
`endif

// ---- hdl/btt_pkg.sv ----
// Types of the boost target tracker.
package btt_pkg;
    typedef logic [5:0] btt_code_t;
    typedef enum logic [1:0] {BTT_IDLE, BTT_HOLD, BTT_RAMP} btt_mode_t;
endpackage : btt_pkg

// ---- hdl/btt_ref_tick.sv ----
// Divider making the one-cycle 2 MHz reference enable.
`timescale 1ns/100ps
`default_nettype none
`include "btt_defines.svh"
module btt_ref_tick #(
    parameter int DIV = `BTT_REF_DIV
) (
    input  wire logic sys_clk,  // System clock.
    input  wire logic rst,      // Synchronous reset.
    output logic      ref_tick  // One pulse per reference period.
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } btt_tick_st_t;
    btt_tick_st_t s_q, s_d;
    if (DIV < 1 || DIV > 65535) begin : g_bad_div
        $error("DIV out of range");
    end
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt == 16'(DIV - 1)) begin
            s_d.cnt = 16'h0000;
            s_d.tick = 1'b1; // R12
        end else begin
            s_d.cnt = s_q.cnt + 16'h0001;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign ref_tick = s_q.tick;
endmodule : btt_ref_tick
`default_nettype wire

// ---- tb/btt_boost_target_tracker_tb.sv ----
// Self-checking testbench for the boost target tracker.
`timescale 1ns/100ps
`default_nettype none
module btt_boost_target_tracker_tb;
    import btt_pkg::*;
    logic       sys_clk, rst, mclk_above_2m, flag_n, conv_on, bypass, ramping, div5, cfg_ok;
    btt_code_t  peak, margin, ceil_c, bat, tgt, sup;
    logic [2:0] step_sel, srate;
    logic [3:0] hold_sel, clk_mult;
    logic [1:0] ratio_sel;
    logic [9:0] eff_x2;
    logic [8:0] osr;
    int         n_errors, total_checks, n, e;
    int         step_us [8] = '{4, 8, 16, 32, 1, 2, 64, 128};
    int         base [3] = '{256, 400, 500};
    btt_boost_target_tracker #(.HOLD_MS_UNIT(2)) dut_u (.sys_clk(sys_clk), .rst(rst),
        .output_peak_level(peak), .boost_signal_margin(margin), .boost_ceiling_code(ceil_c),
        .battery_level_code(bat), .ramp_step_period_sel(step_sel), .stepdown_hold_sel(hold_sel),
        .sample_rate_range(srate), .ratio_sel(ratio_sel), .clk_mult(clk_mult),
        .mclk_above_2m(mclk_above_2m), .boost_target_code(tgt), .boosted_supply(sup),
        .boost_active_flag_n(flag_n), .converter_on(conv_on), .bypass_to_battery(bypass),
        .ramping(ramping), .eff_ratio_x2(eff_x2), .osr_fixed(osr), .auto_div5(div5),
        .cfg_valid(cfg_ok));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    function automatic int calc(int p, int m, int c);
        return (p + m > c) ? c : p + m;
    endfunction : calc
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask : tick
    // Waits for the supply to move (chg) or settle, counting cycles against a limit.
    task automatic wait_sup(input bit chg, input int lim, output int cyc);
        btt_code_t s0;
        s0 = sup;
        cyc = 0;
        while (chg ? sup === s0 : ramping !== 1'b0) begin
            tick(1);
            cyc++;
            if (cyc > lim) begin
                check(16'h0, 16'h1);
                complete_run();
            end
        end
    endtask : wait_sup
    initial begin
        rst = 1'b1; peak = '0; margin = '0; ceil_c = 6'h3F; bat = '0; step_sel = 3'h4;
        hold_sel = '0; srate = '0; ratio_sel = '0; clk_mult = 4'h1; mclk_above_2m = 1'b1;
        n_errors = 0;
        total_checks = 0;
        void'($urandom(32'h2BF6));
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        for (int k = 0; k < 40; k++) begin
            @(posedge sys_clk);
            peak <= (k < 2) ? 6'(11 + k) : 6'($urandom);
            margin <= (k < 2) ? 6'h00 : 6'($urandom);
            ceil_c <= (k < 2) ? 6'h3F : 6'($urandom);
            bat <= (k < 2) ? 6'h00 : 6'($urandom);
            srate <= 3'($urandom % 4);
            tick(4);
            e = calc(peak, margin, ceil_c);
            check(16'(tgt), 16'(e));
            check(16'(flag_n), 16'(e >= bat && e >= 12));
            check(16'(conv_on), 16'(e >= 12 && peak >= bat));
            check(16'(bypass), 16'(!(e >= 12 && peak >= bat)));
        end
        @(posedge sys_clk);
        margin <= '0; ceil_c <= 6'h3F; bat <= '0; peak <= 6'h14;
        tick(2);
        wait_sup(1'b0, 7000, n);
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            step_sel <= 3'(i); peak <= (i % 2) ? 6'h14 : 6'h16;
            tick(1);
            wait_sup(1'b1, step_us[i] * 100 + 100, n);
            check(16'(ramping), 16'h1);
            wait_sup(1'b1, step_us[i] * 100 + 100, n);
            check(16'(n), 16'(step_us[i] * 100));
            wait_sup(1'b0, step_us[i] * 100 + 100, n);
            check(16'(sup), 16'(peak));
        end
        for (int h = 1; h < 5; h++) begin
            @(posedge sys_clk);
            hold_sel <= 4'(h); step_sel <= 3'h4; peak <= 6'h1E;
            tick(3);
            check(16'(tgt), 16'h1E);
            n = (1 << (h - 1)) * 100;
            @(posedge sys_clk) peak <= 6'h14;
            tick(n / 2);
            check(16'(tgt), 16'h1E);
            tick(n / 2 + 60);
            check(16'(tgt), 16'h14);
        end
        for (int r = 0; r < 4; r++) begin
            for (int m = 0; m < 4; m++) begin
                @(posedge sys_clk);
                ratio_sel <= 2'(r); clk_mult <= 4'(1 << m); mclk_above_2m <= (m > 1);
                tick(2);
                check(16'(cfg_ok), 16'(r < 3 && (m == 0 || m > 1)));
                if (r < 3) begin
                    check(16'(eff_x2), 16'(base[r] * 2 >> m));
                    check(16'(osr), (r == 0) ? 16'h0 : 16'h64);
                    check(16'(div5), 16'(r == 2));
                end
            end
        end
        complete_run();
    end
endmodule : btt_boost_target_tracker_tb
`default_nettype wire

// ---- tb/btt_trk_sva.sv ----
// Port assertions for the boost target tracker.
`timescale 1ns/100ps
`default_nettype none
module btt_trk_sva (
    input wire logic               sys_clk,             // Clock.
    input wire logic               rst,                 // Reset.
    input wire btt_pkg::btt_code_t output_peak_level,   // Peak.
    input wire btt_pkg::btt_code_t boost_signal_margin, // Margin.
    input wire btt_pkg::btt_code_t boost_ceiling_code,  // Ceiling.
    input wire btt_pkg::btt_code_t battery_level_code,  // Battery.
    input wire logic [1:0]         ratio_sel,           // Ratio.
    input wire logic [3:0]         clk_mult,            // Multiplier.
    input wire logic               mclk_above_2m,       // Fast clock.
    input wire btt_pkg::btt_code_t boost_target_code,   // Target.
    input wire btt_pkg::btt_code_t boosted_supply,      // Supply.
    input wire logic               boost_active_flag_n, // Active low.
    input wire logic               converter_on,        // Running.
    input wire logic               bypass_to_battery,   // Bypass.
    input wire logic               ramping,             // Ramping.
    input wire logic [8:0]         osr_fixed,           // Oversampling.
    input wire logic               auto_div5,           // Divide by five.
    input wire logic               cfg_valid            // Legal setup.
);
    import btt_pkg::*;
    logic [6:0] sum_w;
    btt_code_t  calc_w;
    btt_code_t  sup_q;
    logic [7:0] gap_q;
    // A sum above the ceiling also covers saturation, since the ceiling is at most 63.
    assign sum_w  = 7'(output_peak_level) + 7'(boost_signal_margin);
    assign calc_w = (sum_w > 7'(boost_ceiling_code)) ? boost_ceiling_code : sum_w[5:0];
    // Cycles since the supply code last moved, saturating.
    always_ff @(posedge sys_clk) begin
        sup_q <= boosted_supply;
        if (rst) begin
            gap_q <= 8'hFF;
        end else if (boosted_supply != sup_q) begin
            gap_q <= 8'h01;
        end else if (gap_q != 8'hFF) begin
            gap_q <= gap_q + 8'h01;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_RISE: assert property (calc_w > boost_target_code |=> boost_target_code == $past(calc_w))
        else $error("target did not follow a rise");
    AST_FLAG: assert property (!$past(rst) |-> boost_active_flag_n ==
        ($past(boost_target_code) >= $past(battery_level_code) && $past(boost_target_code) >= 6'h0C))
        else $error("active flag wrong");
    AST_CONV: assert property (!$past(rst) |-> converter_on ==
        ($past(boost_target_code) >= 6'h0C && $past(output_peak_level) >= $past(battery_level_code)))
        else $error("converter state wrong");
    AST_BYPASS: assert property (!$past(rst) |-> bypass_to_battery == !(
        $past(boost_target_code) >= 6'h0C &&
        $past(output_peak_level) >= $past(battery_level_code)))
        else $error("bypass state wrong");
    AST_ONE_STEP: assert property (!$past(rst) && boosted_supply > $past(boosted_supply) |->
        boosted_supply == $past(boosted_supply) + 6'h01 && $past(ramping))
        else $error("supply step wrong");
    AST_GAP: assert property ($changed(boosted_supply) |=> $stable(boosted_supply)[*8])
        else $error("supply steps too close");
    AST_STEP_GAP: assert property (boosted_supply != sup_q |-> gap_q >= 8'h64)
        else $error("supply step interval too short");
    AST_RAMPING: assert property (ramping == (boosted_supply != boost_target_code))
        else $error("ramping flag wrong");
    AST_OSR: assert property (!$past(rst) && $past(ratio_sel) != 2'h3 |-> auto_div5 ==
        ($past(ratio_sel) == 2'h2) && osr_fixed == ($past(ratio_sel) == 2'h0 ? 9'h000 : 9'h064))
        else $error("oversampling setup wrong");
    AST_CFG: assert property (!$past(rst) |-> cfg_valid == ($past(ratio_sel) != 2'h3 &&
        $past(clk_mult) inside {4'h1, 4'h2, 4'h4, 4'h8} && ($past(clk_mult) == 4'h1 || $past(mclk_above_2m))))
        else $error("clock setup validity wrong");
endmodule : btt_trk_sva
bind btt_boost_target_tracker btt_trk_sva chk_u (.sys_clk, .rst, .output_peak_level,
    .boost_signal_margin, .boost_ceiling_code, .battery_level_code, .ratio_sel, .clk_mult,
    .mclk_above_2m, .boost_target_code, .boosted_supply, .boost_active_flag_n, .converter_on,
    .bypass_to_battery, .ramping, .osr_fixed, .auto_div5, .cfg_valid);
`default_nettype wire
